// file: hdl/iwd_decoder.sv
// Purpose: instruction word and cycle decoder with Wishbone control
// Assumes: program memory returns pm_data_i for pm_addr_o in same cycle
// Notes:   one clock is one instruction cycle; see hand-over for map
// Functional notes
// - accept single-word and 48-bit double-word instructions
// - second word of a double has its top eight bits zero
// - a lone second word executes as a no-operation
// - every double-word instruction takes two cycles
// - single words take one cycle, more on skip, branch, table, sfr
// - every added cycle runs as a no-operation
// - taken skip costs two cycles, three over a double word
// - double-word moves take two cycles
// - file address is direct, zero through 0x1FFF
// - bit position field picks one of sixteen bits
// - unsigned ten-bit literal limited to 255 in byte mode
// - 23-bit program address literal has bit zero clear
// - dsp ops pick accumulator A or B, writeback W13 or [W13]+=2
// - carry, digit carry, negative, overflow, sticky zero flags
// - separate overflow and saturation flags per accumulator
// - size suffix picks byte, word (default) or double; shadow suffix
// - base register field picks W0 through W15
// - signed ten-bit literal is two's complement -512 to 511
// - destination supports direct, indirect, inc, dec and indexed modes
//
// The register addresses and the Wishbone register port were left to the implementer.
`timescale 1ns/10ps
module iwd_decoder #(
    parameter int unsigned CNT_W = 32
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [22:0]      pm_addr_o,
    input  wire logic [23:0] pm_data_i,
    input  wire logic        skip_cond_i,
    input  wire logic        flag_we_i,
    input  wire logic        zero_sticky_i,
    input  wire logic [4:0]  flag_d_i,
    input  wire logic        dsp_flag_we_i,
    input  wire logic [3:0]  dsp_flag_d_i,
    output logic             issue_valid_o,
    output logic             issue_double_o,
    output logic             nop_cycle_o,
    output logic [3:0]       class_o,
    output logic [1:0]       size_o,
    output logic             shadow_o,
    output logic             acc_sel_o,
    output logic [3:0]       base_working_reg_o,
    output logic [3:0]       dest_working_reg_o,
    output logic [2:0]       dest_mode_o,
    output logic [12:0]      file_addr_o,
    output logic [3:0]       bit_pos_field_o,
    output logic [9:0]       unsigned_imm10_o,
    output logic [15:0]      signed_imm10_o,
    output logic [22:0]      unsigned_imm23_o,
    output logic [3:0]       awb_reg_o,
    output logic             awb_indirect_o,
    output logic [1:0]       awb_post_inc_o,
    output logic [4:0]       flags_o,
    output logic [3:0]       dsp_flags_o
);
    localparam int unsigned PW = iwd_pkg::PC_W;

    iwd_pkg::iwd_state_e st_r;
    iwd_pkg::iwd_state_e st_nxt;
    logic [PW-1:0]    pc_r;
    logic [PW-1:0]    pc_nxt;
    logic [23:0]      w1_r;
    logic [23:0]      ld_w1;
    logic [23:0]      ld_w2;
    logic             issue_nxt;
    logic             dbl_nxt;
    logic             nop_nxt;
    logic             badw_set;
    logic             badw_r;
    logic             run_r;
    logic             ack_r;
    logic [CNT_W-1:0] cnt_r;
    logic [31:0]      rd_val;
    logic             wr_fire;
    logic             pc_wr;
    logic [3:0]       cls;
    logic             lone;
    logic             is_dbl;
    logic [PW-1:0]    bra_off;
    logic [PW-1:0]    goto_tgt;

    assign cls    = pm_data_i[iwd_pkg::CLS_HI:iwd_pkg::CLS_LO];
    // the zero top byte is what marks a stray second word
    assign lone   = pm_data_i[iwd_pkg::TOP_HI:iwd_pkg::TOP_LO]
                    == iwd_pkg::SECOND_TOP;
    assign is_dbl = (cls == iwd_pkg::CLS_DMOV)
                    || (cls == iwd_pkg::CLS_DGOTO);
    assign bra_off  = {{(PW-11){pm_data_i[9]}}, pm_data_i[9:0], 1'b0};
    assign goto_tgt = {pm_data_i[6:0], w1_r[15:1], 1'b0};

    // bus writes land on the edge where the master sees ack
    assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;
    assign pc_wr   = wr_fire && (wb_adr_i == iwd_pkg::REG_PC)
                     && (wb_sel_i[2:0] == 3'h7);

    always_comb
    begin
        st_nxt    = st_r;
        pc_nxt    = pc_r;
        issue_nxt = 1'b0;
        dbl_nxt   = 1'b0;
        nop_nxt   = 1'b0;
        badw_set  = 1'b0;
        ld_w1     = pm_data_i;
        ld_w2     = 24'h000000;
        case (st_r)
            iwd_pkg::ST_FIRST:
            begin
                if (!run_r)
                begin
                    // pc only reloads while halted, never mid-sequence
                    if (pc_wr)
                    begin
                        pc_nxt = {wb_dat_i[PW-1:1], 1'b0};
                    end
                end
                else if (lone)
                begin
                    nop_nxt = 1'b1;
                    pc_nxt  = pc_r + iwd_pkg::PC_STEP;
                end
                else if (is_dbl)
                begin
                    st_nxt = iwd_pkg::ST_SECOND;
                    pc_nxt = pc_r + iwd_pkg::PC_STEP;
                end
                else
                begin
                    issue_nxt = 1'b1;
                    pc_nxt    = pc_r + iwd_pkg::PC_STEP;
                    if ((cls == iwd_pkg::CLS_SKIP) && skip_cond_i)
                    begin
                        st_nxt = iwd_pkg::ST_SKIP;
                    end
                    else if (cls == iwd_pkg::CLS_BRA)
                    begin
                        pc_nxt = pc_r + iwd_pkg::PC_STEP + bra_off;
                        st_nxt = iwd_pkg::ST_NOP;
                    end
                    else if ((cls == iwd_pkg::CLS_TBLRD)
                             || (cls == iwd_pkg::CLS_SFRRD))
                    begin
                        st_nxt = iwd_pkg::ST_NOP;
                    end
                end
            end
            iwd_pkg::ST_SECOND:
            begin
                // issue the whole 48-bit instruction now
                issue_nxt = 1'b1;
                dbl_nxt   = 1'b1;
                ld_w1     = w1_r;
                ld_w2     = pm_data_i;
                badw_set  = !lone;
                st_nxt    = iwd_pkg::ST_FIRST;
                if (w1_r[iwd_pkg::CLS_HI:iwd_pkg::CLS_LO]
                    == iwd_pkg::CLS_DGOTO)
                begin
                    pc_nxt = goto_tgt;
                end
                else
                begin
                    pc_nxt = pc_r + iwd_pkg::PC_STEP;
                end
            end
            iwd_pkg::ST_SKIP:
            begin
                nop_nxt = 1'b1;
                if (is_dbl)
                begin
                    pc_nxt = pc_r + iwd_pkg::PC_STEP + iwd_pkg::PC_STEP;
                    st_nxt = iwd_pkg::ST_NOP;
                end
                else
                begin
                    pc_nxt = pc_r + iwd_pkg::PC_STEP;
                    st_nxt = iwd_pkg::ST_FIRST;
                end
            end
            iwd_pkg::ST_NOP:
            begin
                nop_nxt = 1'b1;
                st_nxt  = iwd_pkg::ST_FIRST;
            end
            default:
            begin
                st_nxt = iwd_pkg::ST_FIRST;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            st_r           <= iwd_pkg::ST_FIRST;
            pc_r           <= iwd_pkg::PC_RESET;
            w1_r           <= 24'h000000;
            issue_valid_o  <= 1'b0;
            issue_double_o <= 1'b0;
            nop_cycle_o    <= 1'b0;
        end
        else
        begin
            st_r           <= st_nxt;
            pc_r           <= pc_nxt;
            issue_valid_o  <= issue_nxt;
            issue_double_o <= dbl_nxt;
            nop_cycle_o    <= nop_nxt;
            if (st_r == iwd_pkg::ST_FIRST)
            begin
                w1_r <= pm_data_i;
            end
        end
    end

    assign pm_addr_o = pc_r;

    iwd_fields u_fields (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .load_i             (issue_nxt),
        .w1_i               (ld_w1),
        .w2_i               (ld_w2),
        .class_o            (class_o),
        .size_o             (size_o),
        .shadow_o           (shadow_o),
        .acc_sel_o          (acc_sel_o),
        .base_working_reg_o (base_working_reg_o),
        .dest_working_reg_o (dest_working_reg_o),
        .dest_mode_o        (dest_mode_o),
        .file_addr_o        (file_addr_o),
        .bit_pos_field_o    (bit_pos_field_o),
        .unsigned_imm10_o   (unsigned_imm10_o),
        .signed_imm10_o     (signed_imm10_o),
        .unsigned_imm23_o   (unsigned_imm23_o),
        .awb_reg_o          (awb_reg_o),
        .awb_indirect_o     (awb_indirect_o),
        .awb_post_inc_o     (awb_post_inc_o)
    );

    iwd_flag_reg #(
        .W      (5),
        .STICKY (5'h10)
    ) u_mcu_flags (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .we_i     (flag_we_i),
        .sticky_i (zero_sticky_i),
        .d_i      (flag_d_i),
        .q_o      (flags_o)
    );

    iwd_flag_reg #(
        .W      (4),
        .STICKY (4'h0)
    ) u_dsp_flags (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .we_i     (dsp_flag_we_i),
        .sticky_i (1'b0),
        .d_i      (dsp_flag_d_i),
        .q_o      (dsp_flags_o)
    );

    // wishbone: ack one cycle after the strobe, dropped the next
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r    <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
            if (wb_cyc_i && wb_stb_i && !ack_r)
            begin
                wb_dat_o <= rd_val;
            end
        end
    end
    assign wb_ack_o = ack_r;

    always_comb
    begin
        rd_val = 32'h00000000;
        if (wb_adr_i == iwd_pkg::REG_CTRL)
        begin
            rd_val = {31'h00000000, run_r};
        end
        else if (wb_adr_i == iwd_pkg::REG_STATUS)
        begin
            rd_val = {18'h00000, st_r, dsp_flags_o, flags_o, badw_r};
        end
        else if (wb_adr_i == iwd_pkg::REG_PC)
        begin
            rd_val = {9'h000, pc_r};
        end
        else if (wb_adr_i == iwd_pkg::REG_COUNT)
        begin
            rd_val = 32'(cnt_r);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            run_r <= 1'b0;
        end
        else if (wr_fire && (wb_adr_i == iwd_pkg::REG_CTRL) && wb_sel_i[0])
        begin
            run_r <= wb_dat_i[0];
        end
    end

    // set wins over a simultaneous write-one clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            badw_r <= 1'b0;
        end
        else if (badw_set)
        begin
            badw_r <= 1'b1;
        end
        else if (wr_fire && (wb_adr_i == iwd_pkg::REG_STATUS)
                 && wb_sel_i[0] && wb_dat_i[0])
        begin
            badw_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_r <= '0;
        end
        else if (wr_fire && (wb_adr_i == iwd_pkg::REG_COUNT))
        begin
            cnt_r <= '0;
        end
        else if (issue_nxt)
        begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // checks
    sequence s_dbl_start;
        (st_r == iwd_pkg::ST_FIRST) && run_r && !lone && is_dbl;
    endsequence
    sequence s_skip_taken;
        (st_r == iwd_pkg::ST_FIRST) && run_r && !lone && !is_dbl
        && (cls == iwd_pkg::CLS_SKIP) && skip_cond_i;
    endsequence
    sequence s_single_plain;
        (st_r == iwd_pkg::ST_FIRST) && run_r && !lone && !is_dbl
        && (cls == iwd_pkg::CLS_ALU);
    endsequence

    AST_DBL_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
        s_dbl_start |=> (st_r == iwd_pkg::ST_SECOND) && !issue_valid_o
        ##1 issue_valid_o && issue_double_o && !nop_cycle_o)
        else $error("double word not issued in two cycles");
    AST_NO_GAP: assert property (@(posedge clk_i) disable iff (rst_i)
        s_dbl_start |=> pm_addr_o == $past(pm_addr_o) + iwd_pkg::PC_STEP)
        else $error("second word not fetched next");
    AST_LONE_NOP: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r == iwd_pkg::ST_FIRST) && run_r && lone
        |=> nop_cycle_o && !issue_valid_o)
        else $error("lone second word not a nop");
    AST_SKIP_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_skip_taken ##1 !is_dbl
        |=> nop_cycle_o && (st_r == iwd_pkg::ST_FIRST))
        else $error("skip over single word not two cycles");
    AST_SKIP_TWO: assert property (@(posedge clk_i) disable iff (rst_i)
        s_skip_taken ##1 is_dbl
        |=> nop_cycle_o && (st_r == iwd_pkg::ST_NOP)
        ##1 nop_cycle_o && (st_r == iwd_pkg::ST_FIRST))
        else $error("skip over double word not three cycles");
    AST_BRA_NOP: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_r == iwd_pkg::ST_FIRST) && run_r && !lone && !is_dbl
        && (cls == iwd_pkg::CLS_BRA)
        |=> issue_valid_o ##1 nop_cycle_o && !issue_valid_o)
        else $error("branch lacks its nop cycle");
    AST_SINGLE_ONE: assert property (@(posedge clk_i) disable iff (rst_i)
        s_single_plain |=> issue_valid_o && (st_r == iwd_pkg::ST_FIRST))
        else $error("plain single word took extra cycles");
    AST_IMM23_EVEN: assert property (@(posedge clk_i) disable iff (rst_i)
        issue_valid_o |-> !unsigned_imm23_o[0])
        else $error("program address literal odd");
    AST_BYTE_IMM: assert property (@(posedge clk_i) disable iff (rst_i)
        issue_valid_o && (size_o == iwd_pkg::SZ_BYTE)
        |-> unsigned_imm10_o[9:8] == 2'h0)
        else $error("byte literal above 255");
    AST_ZERO_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
        flag_we_i && zero_sticky_i && !flags_o[iwd_pkg::FL_Z]
        |=> !flags_o[iwd_pkg::FL_Z])
        else $error("sticky zero flag was set");
    AST_ACK_DROP: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule

// file: common/iwd_pkg.sv
// Purpose: shared constants and types for the instruction word decoder
// Assumes: 24-bit program words, 23-bit program addresses stepping by 2
// Notes:   opcode class and register map are fixed here for all files
package iwd_pkg;
    localparam int unsigned WORD_W = 24;
    localparam int unsigned PC_W   = 23;
    localparam int unsigned WB_AW  = 8;
    // word layout
    localparam int unsigned CLS_HI    = 23;
    localparam int unsigned CLS_LO    = 20;
    localparam int unsigned TOP_HI    = 23;
    localparam int unsigned TOP_LO    = 16;
    localparam int unsigned SIZE_LO   = 18;
    localparam int unsigned SHADOW_B  = 17;
    localparam int unsigned ACC_B     = 16;
    localparam int unsigned BASE_LO   = 12;
    localparam int unsigned AWB_IND_B = 11;
    localparam int unsigned DMODE_LO  = 9;
    localparam int unsigned DREG_LO   = 5;
    localparam logic [7:0]  SECOND_TOP = 8'h00;
    localparam logic [12:0] FILE_ADDR_MAX = 13'h1FFF;
    // opcode classes
    localparam logic [3:0] CLS_ALU   = 4'h1;
    localparam logic [3:0] CLS_DMOV  = 4'h2;
    localparam logic [3:0] CLS_DGOTO = 4'h3;
    localparam logic [3:0] CLS_SKIP  = 4'h4;
    localparam logic [3:0] CLS_BRA   = 4'h5;
    localparam logic [3:0] CLS_TBLRD = 4'h6;
    localparam logic [3:0] CLS_SFRRD = 4'h7;
    localparam logic [3:0] CLS_DSP   = 4'h8;
    // size suffix and destination modes
    localparam logic [1:0] SZ_WORD  = 2'h0;
    localparam logic [1:0] SZ_BYTE  = 2'h1;
    localparam logic [1:0] SZ_DWORD = 2'h2;
    localparam logic [2:0] DM_INDEXED = 3'h6;
    localparam logic [3:0] AWB_REG = 4'hD;
    localparam logic [1:0] AWB_INC = 2'h2;
    localparam logic [PC_W-1:0] PC_STEP  = 23'h000002;
    localparam logic [PC_W-1:0] PC_RESET = 23'h000000;
    // register map and bits
    localparam logic [WB_AW-1:0] REG_CTRL   = 8'h00;
    localparam logic [WB_AW-1:0] REG_STATUS = 8'h04;
    localparam logic [WB_AW-1:0] REG_PC     = 8'h08;
    localparam logic [WB_AW-1:0] REG_COUNT  = 8'h0C;
    localparam int unsigned FL_Z = 4;
    typedef enum logic [3:0] {
        ST_FIRST  = 4'h1,
        ST_SECOND = 4'h2,
        ST_SKIP   = 4'h4,
        ST_NOP    = 4'h8
    } iwd_state_e;
endpackage

// file: hdl/iwd_flag_reg.sv
// Purpose: status flag group with optional sticky bits
// Assumes: d_i sampled when we_i is high
// Notes:   sticky bits can only clear while sticky_i is high
`timescale 1ns/10ps
module iwd_flag_reg #(
    parameter int unsigned   W      = 5,
    parameter logic [W-1:0]  STICKY = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         we_i,
    input  wire logic         sticky_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            q_o <= '0;
        end
        else if (we_i)
        begin
            // sticky bits keep a clear across multi-step sequences
            if (sticky_i)
            begin
                q_o <= (d_i & ~STICKY) | (d_i & q_o & STICKY);
            end
            else
            begin
                q_o <= d_i;
            end
        end
    end
endmodule

// file: hdl/iwd_fields.sv
// Purpose: operand field extraction for one issued instruction
// Assumes: load_i pulses once per issue, w2_i zero for single words
// Notes:   all outputs are flip-flops, stable until the next issue
`timescale 1ns/10ps
module iwd_fields (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        load_i,
    input  wire logic [23:0] w1_i,
    input  wire logic [23:0] w2_i,
    output logic [3:0]       class_o,
    output logic [1:0]       size_o,
    output logic             shadow_o,
    output logic             acc_sel_o,
    output logic [3:0]       base_working_reg_o,
    output logic [3:0]       dest_working_reg_o,
    output logic [2:0]       dest_mode_o,
    output logic [12:0]      file_addr_o,
    output logic [3:0]       bit_pos_field_o,
    output logic [9:0]       unsigned_imm10_o,
    output logic [15:0]      signed_imm10_o,
    output logic [22:0]      unsigned_imm23_o,
    output logic [3:0]       awb_reg_o,
    output logic             awb_indirect_o,
    output logic [1:0]       awb_post_inc_o
);
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            class_o            <= 4'h0;
            size_o             <= iwd_pkg::SZ_WORD;
            shadow_o           <= 1'b0;
            acc_sel_o          <= 1'b0;
            base_working_reg_o <= 4'h0;
            dest_working_reg_o <= 4'h0;
            dest_mode_o        <= 3'h0;
            file_addr_o        <= 13'h0000;
            bit_pos_field_o    <= 4'h0;
            unsigned_imm10_o   <= 10'h000;
            signed_imm10_o     <= 16'h0000;
            unsigned_imm23_o   <= 23'h000000;
            awb_reg_o          <= 4'h0;
            awb_indirect_o     <= 1'b0;
            awb_post_inc_o     <= 2'h0;
        end
        else if (load_i)
        begin
            class_o            <= w1_i[iwd_pkg::CLS_HI:iwd_pkg::CLS_LO];
            size_o             <= w1_i[iwd_pkg::SIZE_LO+:2];
            shadow_o           <= w1_i[iwd_pkg::SHADOW_B];
            acc_sel_o          <= w1_i[iwd_pkg::ACC_B];
            base_working_reg_o <= w1_i[iwd_pkg::BASE_LO+:4];
            dest_working_reg_o <= w1_i[iwd_pkg::DREG_LO+:4];
            dest_mode_o        <= w1_i[iwd_pkg::DMODE_LO+:3];
            file_addr_o        <= w1_i[12:0] & iwd_pkg::FILE_ADDR_MAX;
            bit_pos_field_o    <= w1_i[3:0];
            // byte ops only see the low eight bits of the literal
            if (w1_i[iwd_pkg::SIZE_LO+:2] == iwd_pkg::SZ_BYTE)
            begin
                unsigned_imm10_o <= {2'h0, w1_i[7:0]};
            end
            else
            begin
                unsigned_imm10_o <= w1_i[9:0];
            end
            signed_imm10_o     <= {{6{w1_i[9]}}, w1_i[9:0]};
            unsigned_imm23_o   <= {w2_i[6:0], w1_i[15:1], 1'b0};
            awb_reg_o          <= iwd_pkg::AWB_REG;
            awb_indirect_o     <= w1_i[iwd_pkg::AWB_IND_B];
            awb_post_inc_o     <= w1_i[iwd_pkg::AWB_IND_B] ?
                                  iwd_pkg::AWB_INC : 2'h0;
        end
    end
endmodule

// file: dv/iwd_pm_model.sv
// Purpose: program memory model feeding the decoder
// Assumes: combinational read of the word at pm_addr_i
// Notes:   unlisted addresses hold a plain single-word alu op
`timescale 1ns/10ps
module iwd_pm_model (
    input  wire logic [22:0] pm_addr_i,
    output logic      [23:0] pm_data_o
);
    always_comb
    begin
        case (pm_addr_i)
            23'h000000: pm_data_o = 24'h14F3FF;
            23'h000002: pm_data_o = 24'h200CA0;
            23'h000004: pm_data_o = 24'h00ABCD;
            23'h000006: pm_data_o = 24'h400000;
            23'h000008: pm_data_o = 24'h300000;
            23'h00000A: pm_data_o = 24'h000000;
            23'h00000C: pm_data_o = 24'h000000;
            23'h00000E: pm_data_o = 24'h300020;
            23'h000010: pm_data_o = 24'h000000;
            23'h000020: pm_data_o = 24'h500000;
            23'h000022: pm_data_o = 24'h830800;
            23'h000024: pm_data_o = 24'h400000;
            23'h000028: pm_data_o = 24'h600000;
            23'h00002C: pm_data_o = 24'h700000;
            default:    pm_data_o = 24'h100000;
        endcase
    end
endmodule

// file: dv/test_instruction_word_cycle_decoder.sv
// Purpose: self-checking bench for the instruction word decoder
// Assumes: skip condition held true, so every skip is taken
// Notes:   issue stream judged by event codes and cycle offsets
`timescale 1ns/10ps
module test_instruction_word_cycle_decoder;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic skip_cond_i = 1, flag_we_i = 0, zero_sticky_i = 0;
    logic dsp_flag_we_i = 0, wb_ack_o, issue_valid_o, issue_double_o;
    logic nop_cycle_o, shadow_o, acc_sel_o, awb_indirect_o;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 4'hF, dsp_flag_d_i = 0, class_o, awb_reg_o;
    logic [3:0] base_working_reg_o, dest_working_reg_o, bit_pos_field_o;
    logic [3:0] dsp_flags_o;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q;
    logic [22:0] pm_addr_o, unsigned_imm23_o;
    logic [23:0] pm_data_i;
    logic [4:0] flag_d_i = 0, flags_o;
    logic [1:0] size_o, awb_post_inc_o;
    logic [2:0] dest_mode_o;
    logic [12:0] file_addr_o;
    logic [9:0] unsigned_imm10_o;
    logic [15:0] signed_imm10_o;
    logic [2:0] ev_code [$];
    int ev_cyc [$];
    int cyc_n = 0, mismatches = 0, total_checks = 0;
    iwd_decoder DUT (.*);
    iwd_pm_model PM (.pm_addr_i(pm_addr_o), .pm_data_o(pm_data_i));
    always #2 clk_i = ~clk_i;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        // only ack or the bench timeout ends this wait
        while (wb_ack_o !== 1'b1)
        begin
            @(posedge clk_i);
        end
        r = wb_dat_o;
        wb_cyc_i <= 0; wb_stb_i <= 0;
        @(posedge clk_i);
    endtask
    task automatic t_flags;
        flag_we_i <= 1; flag_d_i <= 5'h0F; dsp_flag_we_i <= 1;
        dsp_flag_d_i <= 4'hA;
        @(posedge clk_i);
        // sticky load: zero may not set, other bits load
        flag_d_i <= 5'h11; zero_sticky_i <= 1; dsp_flag_we_i <= 0;
        @(posedge clk_i);
        flag_we_i <= 0;
        repeat (2) @(posedge clk_i);
        chk(flags_o, 5'h01);
        chk(dsp_flags_o, 4'hA);
        wb(0, 8'hF0, 0, q);
        chk(q, 0);
        $display("flags and bus test done");
    endtask
    task automatic t_stream;
        logic [2:0] ec [17] = '{2, 6, 2, 1, 1, 1, 6, 2, 1, 2,
                                2, 1, 2, 1, 2, 2, 1};
        int eo [17] = '{0, 2, 3, 4, 5, 6, 8, 9, 10, 11,
                        12, 13, 14, 15, 16, 17, 18};
        wb(1, iwd_pkg::REG_CTRL, 1, q);
        wb(0, iwd_pkg::REG_CTRL, 0, q);
        chk(q, 1);
        repeat (20) @(posedge clk_i);
        wb(1, iwd_pkg::REG_CTRL, 0, q);
        wb(0, iwd_pkg::REG_STATUS, 0, q);
        chk(q, 32'h682);
        wb(1, iwd_pkg::REG_PC, 32'h25, q);
        wb(0, iwd_pkg::REG_PC, 0, q);
        chk(q, 32'h24);
        chk(pm_addr_o, 23'h24);
        chk(ev_code.size(), 17);
        for (int i = 0; i < 17; i++)
        begin
            chk(ev_code[i], ec[i]);
            chk(ev_cyc[i] - ev_cyc[0], eo[i]);
        end
        $display("stream test done");
    endtask
    // field outputs sampled at issue events 1, 2, 7 and 10
    always @(posedge clk_i)
    begin
        cyc_n++;
        if ((issue_valid_o | nop_cycle_o) === 1'b1 && ev_code.size() < 17)
        begin
            ev_code.push_back({issue_double_o, issue_valid_o, nop_cycle_o});
            ev_cyc.push_back(cyc_n);
            case (ev_code.size())
                1:
                begin
                    chk({class_o, size_o, acc_sel_o, base_working_reg_o},
                        {iwd_pkg::CLS_ALU, iwd_pkg::SZ_BYTE, 5'h0F});
                    chk({file_addr_o, bit_pos_field_o, unsigned_imm10_o},
                        {13'h13FF, 4'hF, 10'h0FF});
                    chk(signed_imm10_o, 16'hFFFF);
                end
                2: chk({class_o, dest_mode_o, dest_working_reg_o},
                       {iwd_pkg::CLS_DMOV, iwd_pkg::DM_INDEXED, 4'h5});
                7: chk(unsigned_imm23_o, 23'h20);
                10: chk({class_o, acc_sel_o, shadow_o, awb_reg_o,
                         awb_indirect_o, awb_post_inc_o},
                        {iwd_pkg::CLS_DSP, 1'b1, 1'b1, iwd_pkg::AWB_REG,
                         1'b1, iwd_pkg::AWB_INC});
                default: ;
            endcase
        end
        // the whole run needs well under a hundred cycles
        if (cyc_n > 3000)
        begin
            mismatches++;
            close_out();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        t_flags();
        t_stream();
        close_out();
    end
endmodule
